// ===== verification/analog_input_param_cycle_ctrl_asserts.sv
`timescale 1ns/1ps
`include "ai_cycle_regs.vh"
// =====================================================
// port-level checks of the cycle controller
module analog_input_param_cycle_ctrl_asserts #(
   parameter integer HALF_MS = 25000
) (
   input logic        clk_i,
   input logic        nrst_i,
   input logic [7:0]  addr_i,
   input logic [31:0] wdata_i,
   input logic        wr_i,
   input logic        rd_i,
   input logic [31:0] rdata_o,
   input logic        run_i,
   input logic        conv_start_o,
   input logic [1:0]  conv_chan_o,
   input logic [1:0]  conv_range_o,
   input logic        conv_done_i,
   input logic [15:0] conv_data_i,
   input logic        conv_open_i,
   input logic        diag_irq_en_o,
   input logic        hw_irq_o,
   input logic        irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // =====================================================
   // converter handshake
   a_start_pulse: assert property (
      conv_start_o |=> !conv_start_o [*2]) else $error("start pulse too long");
   a_chan_hold: assert property (
      conv_start_o |=> $stable(conv_chan_o) && $stable(conv_range_o))
      else $error("channel setting moved in conversion");
   a_range_legal: assert property (
      conv_start_o |-> conv_range_o != 2'h3) else $error("illegal range code");
   // =====================================================
   // interrupts, read data and parameter transfer
   a_hw_pulse: assert property (
      hw_irq_o |=> !hw_irq_o [*2]) else $error("hardware irq not a pulse");
   a_irq_masked: assert property (
      wr_i && addr_i == `REG_IRQ_MASK && wdata_i[2:0] == 3'h0 |=> !irq_o)
      else $error("irq high while masked");
   a_rdata_idle: assert property (
      !rd_i |=> rdata_o == 32'h0000_0000) else $error("read data without read");
   a_diag_hold: assert property (
      !run_i [*6] |=> $stable(diag_irq_en_o)) else $error("params applied in stop");
   a_diag_from_run: assert property (
      $rose(diag_irq_en_o) |-> $past(run_i, 2)) else $error("params applied early");
endmodule // analog_input_param_cycle_ctrl_asserts

bind analog_input_param_cycle_ctrl analog_input_param_cycle_ctrl_asserts #(
   .HALF_MS(HALF_MS)
) u_asserts (.*);

// ===== verification/conv_model.sv
`timescale 1ns/1ps
// =====================================================
// converter model, latency grows with channel number
module conv_model #(
   parameter [3:0] OPEN_MASK = 4'b1100
) (
   input  wire        clk_i,
   input  wire        nrst_i,
   input  wire        start_i,
   input  wire [1:0]  chan_i,
   input  wire [1:0]  range_i,
   output reg         done_o,
   output reg  [15:0] data_o,
   output reg         open_o
);
   reg [3:0] cnt;
   reg [1:0] ch;
   reg       busy;
   // conversion timing; bus toggles outside done
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         busy <= 1'b0; cnt <= 4'h0; ch <= 2'h0;
         done_o <= 1'b0; data_o <= 16'h0000; open_o <= 1'b0;
      end
      else
      begin
         done_o <= 1'b0;
         if (start_i)
         begin
            busy <= 1'b1; ch <= chan_i; cnt <= 4'h2 + chan_i; data_o <= ~data_o;
         end
         else if (busy && cnt == 4'h0)
         begin
            busy <= 1'b0; done_o <= 1'b1;
            data_o <= {12'h3A5, 2'b00, ch}; open_o <= OPEN_MASK[ch];
         end
         else
         begin
            if (busy) cnt <= cnt - 4'h1;
            data_o <= ~data_o; open_o <= ~open_o;
         end
      end
   end
endmodule // conv_model

// ===== verification/test_analog_input_param_cycle_ctrl.sv
`timescale 1ns/1ps
`include "ai_cycle_regs.vh"
`define CHK(n,e,g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_analog_input_param_cycle_ctrl;
   reg         clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, run_i = 0;
   reg  [7:0]  addr_i = 8'h00;
   reg  [31:0] wdata_i = 32'h0000_0000;
   reg  [31:0] d;
   wire [31:0] rdata_o;
   wire [15:0] conv_data_i;
   wire [1:0]  conv_chan_o, conv_range_o;
   wire        conv_start_o, conv_done_i, conv_open_i, diag_irq_en_o, hw_irq_o, irq_o;
   integer     bad_count = 0, n_tests = 0, i, k;
   // =====================================================
   // design and converter
   analog_input_param_cycle_ctrl #(.HALF_MS(10)) u_analog_input_param_cycle_ctrl (.*);
   conv_model u_conv_model (.clk_i, .nrst_i, .start_i(conv_start_o), .chan_i(conv_chan_o),
      .range_i(conv_range_o), .done_o(conv_done_i), .data_o(conv_data_i), .open_o(conv_open_i));
   // clock
   initial forever #10 clk_i = ~clk_i;
   // =====================================================
   // bus and wait helpers
   task wr(input [7:0] a, input [31:0] v);
   begin
      @(posedge clk_i); addr_i <= a; wdata_i <= v; wr_i <= 1'b1;
      @(posedge clk_i); wr_i <= 1'b0; #1;
   end
   endtask
   task rd(input [7:0] a);
   begin
      @(posedge clk_i); addr_i <= a; rd_i <= 1'b1;
      @(posedge clk_i); rd_i <= 1'b0; #1 d = rdata_o;
   end
   endtask
   task exp_start(input [1:0] c, input [1:0] r);
   begin
      k = 0;
      while (conv_start_o !== 1'b1 && k < 200) begin @(posedge clk_i); #1 k++; end
      `CHK("start", 1'b1, conv_start_o)
      `CHK("chan", c, conv_chan_o)
      `CHK("range", r, conv_range_o)
      @(posedge clk_i); #1;
   end
   endtask
   task wait_hw;
   begin
      k = 0;
      while (hw_irq_o !== 1'b1 && k < 300) begin @(posedge clk_i); #1 k++; end
      `CHK("hw_irq", 1'b1, hw_irq_o)
   end
   endtask
   // =====================================================
   // scenarios
   task t_reset;
   begin
      rd(`REG_DYN_CH);  `CHK("dyn_ch", 32'h0000_1111, d)
      rd(`REG_DYN_CYC); `CHK("dyn_cyc", 32'h0000_0020, d)
      rd(`REG_CTRL);    `CHK("ctrl", 32'h0000_0000, d)
      rd(8'h3C);        `CHK("unmapped", 32'h0000_0000, d)
   end
   endtask
   task t_load_scan;
   begin
      wr(`REG_STATIC, 32'h0000_0441);
      wr(`REG_DYN_CH, 32'h0000_6A01);
      wr(`REG_DYN_CYC, 32'h0000_0106);
      wr(`REG_DYN_CYC, 32'h0000_0105);
      rd(`REG_DYN_CYC); `CHK("ival", 32'h0000_0106, d)
      wr(`REG_IRQ_MASK, 32'h0000_0007);
      repeat (8) @(posedge clk_i);
      `CHK("diag_stop", 1'b0, diag_irq_en_o)
      run_i <= 1'b1;
      exp_start(2'h0, 2'h0);
      exp_start(2'h2, 2'h2);
      exp_start(2'h3, 2'h1);
      repeat (12) @(posedge clk_i);
      rd(`REG_IRQ_STAT); `CHK("irq_stat", 2'b11, d[2:1])
      `CHK("irq", 1'b1, irq_o)
      wr(`REG_IRQ_MASK, 32'h0000_0000); `CHK("irq_mask", 1'b0, irq_o)
      wr(`REG_IRQ_STAT, 32'h0000_0007);
      rd(`REG_IRQ_STAT); `CHK("irq_clr", 2'b00, d[2:1])
      rd(`REG_STATUS); `CHK("status", 32'h0000_040D, d)
      `CHK("diag_run", 1'b1, diag_irq_en_o)
      for (i = 0; i < 4; i++)
         if (i != 1)
         begin
            rd(`REG_RESULT0 + 4 * i); `CHK("result", 16'h3A50 + i, d[15:0])
         end
   end
   endtask
   task t_interval;
   begin
      wait_hw;
      @(posedge clk_i); #1;
      wait_hw;
      `CHK("period", 1'b1, k >= 58 && k <= 60)
      exp_start(2'h0, 2'h0);
   end
   endtask
   task t_dynamic;
   begin
      wr(`REG_DYN_CH, 32'h0000_1111);
      wr(`REG_STATIC, 32'h0000_0000);
      rd(`REG_CTRL); `CHK("ctrl_run", 3'b111, d[2:0])
      wait_hw;
      exp_start(2'h0, 2'h0);
      exp_start(2'h1, 2'h0);
      `CHK("diag_kept", 1'b1, diag_irq_en_o)
      @(posedge clk_i);
      run_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      run_i <= 1'b1;
      repeat (10) @(posedge clk_i); #1;
      `CHK("diag_new", 1'b0, diag_irq_en_o)
   end
   endtask
   // =====================================================
   // verdict
   task report_and_stop;
   begin
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   end
   endtask
   // watchdog
   initial
   begin
      #100000;
      bad_count++;
      report_and_stop;
   end
   // main sequence
   initial
   begin
      repeat (6) @(posedge clk_i);
      nrst_i <= 1'b1;
      t_reset;
      t_load_scan;
      t_interval;
      t_dynamic;
      report_and_stop;
   end
endmodule // test_analog_input_param_cycle_ctrl

// ===== verilog/ai_cycle_regs.vh
`ifndef AI_CYCLE_REGS_VH
`define AI_CYCLE_REGS_VH
// =====================================================
// register offsets (byte addresses)
`define REG_CTRL        8'h00
`define REG_STATIC      8'h04
`define REG_DYN_CH      8'h08
`define REG_DYN_CYC     8'h0C
`define REG_STATUS      8'h10
`define REG_IRQ_STAT    8'h14
`define REG_IRQ_MASK    8'h18
`define REG_RESULT0     8'h20
// =====================================================
// field encodings
`define MTYPE_OFF       2'h0
`define MTYPE_VOLT      2'h1
`define MTYPE_CURR      2'h2
`define MRANGE_10V      2'h0
`define MRANGE_20MA     2'h1
`define MRANGE_4_20MA   2'h2
// per-channel dynamic field: type[1:0], range[3:2], 4 bits per channel
`define DYN_CH_RESET    16'h1111
// interval code: 0 unsolicited, n = 6..32 gives n half-milliseconds
`define IVAL_DEFAULT    6'h20
`define IVAL_MIN        6'h06
`define IVAL_MAX        6'h20
// =====================================================
// timing
`define CLK_HZ          50000000
`define HALF_MS_US      500
`define HALF_MS_CYCLES  ((`CLK_HZ / 1000000) * `HALF_MS_US)
// irq status bits
`define IRQ_CYCLE       0
`define IRQ_WBREAK      1
`define IRQ_DONE        2
`endif

// ===== verilog/analog_input_param_cycle_ctrl.v
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`include "ai_cycle_regs.vh"
// =====================================================
// analog input parameter and measurement-cycle control
module analog_input_param_cycle_ctrl #(
   parameter integer HALF_MS = `HALF_MS_CYCLES
) (
   // clock and reset
   input  wire        clk_i,
   input  wire        nrst_i,
   // register port
   input  wire [7:0]  addr_i,
   input  wire [31:0] wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   output reg  [31:0] rdata_o,
   // cpu mode (pin, synchronised)
   input  wire        run_i,
   // converter
   output reg         conv_start_o,
   output reg  [1:0]  conv_chan_o,
   output reg  [1:0]  conv_range_o,
   input  wire        conv_done_i,
   input  wire [15:0] conv_data_i,
   input  wire        conv_open_i,
   // shared diagnostic interrupt enable, to other i/o
   output wire        diag_irq_en_o,
   // interrupts
   output wire        hw_irq_o,
   output wire        irq_o
);
   // =====================================================
   // staged (loaded) and active parameters
   reg        ld_diag_irq_en;
   reg [3:0]  ld_diag_en;
   reg [3:0]  ld_wb_en;
   reg [15:0] ld_dyn;
   reg        ld_cyc_en;
   reg [5:0]  ld_ival;
   reg        act_diag_irq_en;
   reg [3:0]  act_diag_en;
   reg [3:0]  act_wb_en;
   reg [15:0] act_dyn;
   reg        act_cyc_en;
   reg [5:0]  act_ival;
   reg        dyn_pend;
   reg [15:0] result [0:3];
   reg [3:0]  wbreak;
   reg [2:0]  irq_stat;
   reg [2:0]  irq_mask;
   reg        run_s1;
   reg        run_s2;
   reg        run_d;
   reg        applied;
   reg [1:0]  state;
   reg [2:0]  next_ch;
   reg [5:0]  ival_cnt;
   reg        hw_irq;
   wire       go_run;
   wire       tick;
   wire       sel_found;
   wire [1:0] sel_ch;
   wire [3:0] sel_fld;
   wire [3:0] active;
   wire       boundary;
   wire       cyc_event;
   wire       wb_event;
   wire       done_event;
   wire [2:0] irq_set;
   genvar     g;

   localparam [1:0] S_IDLE = 2'd0;
   localparam [1:0] S_PICK = 2'd1;
   localparam [1:0] S_CONV = 2'd2;
   localparam [1:0] S_WAIT = 2'd3;

   // field extract for one channel
   function [3:0] chf;
      input [15:0] v;
      input [1:0]  c;
      begin
         chf = v[c*4 +: 4];
      end
   endfunction

   // =====================================================
   // run pin synchroniser and stop-to-run edge
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         run_s1 <= 1'b0;
         run_s2 <= 1'b0;
         run_d  <= 1'b0;
         applied <= 1'b0;
      end
      else
      begin
         run_s1 <= run_i;
         run_s2 <= run_s1;
         run_d  <= run_s2;
         applied <= go_run; // new set active from here on
      end
   end
   assign go_run = run_s2 && !run_d;

   // channel is active when its type is not deactivated
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_act
         assign active[g] = (act_dyn[g*4 +: 2] != `MTYPE_OFF);
      end
   endgenerate

   assign boundary = (state == S_IDLE);
   assign sel_fld  = chf(act_dyn, sel_ch);

   // =====================================================
   // register writes, parameter staging and activation
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ld_diag_irq_en  <= 1'b0;
         ld_diag_en      <= 4'h0;
         ld_wb_en        <= 4'h0;
         ld_dyn          <= `DYN_CH_RESET;
         ld_cyc_en       <= 1'b0;
         ld_ival         <= `IVAL_DEFAULT;
         act_diag_irq_en <= 1'b0;
         act_diag_en     <= 4'h0;
         act_wb_en       <= 4'h0;
         act_dyn         <= `DYN_CH_RESET;
         act_cyc_en      <= 1'b0;
         act_ival        <= `IVAL_DEFAULT;
         dyn_pend        <= 1'b0;
         irq_mask        <= 3'h0;
      end
      else
      begin
         if (wr_i)
         begin
            case (addr_i)
               `REG_STATIC:
               begin
                  ld_diag_irq_en <= wdata_i[0];
                  ld_diag_en     <= wdata_i[7:4];
                  ld_wb_en       <= wdata_i[11:8];
               end
               `REG_DYN_CH:
                  ld_dyn <= wdata_i[15:0];
               `REG_DYN_CYC:
               begin
                  ld_cyc_en <= wdata_i[8];
                  if (wdata_i[5:0] == 6'h00 ||
                      (wdata_i[5:0] >= `IVAL_MIN && wdata_i[5:0] <= `IVAL_MAX))
                     ld_ival <= wdata_i[5:0];
               end
               `REG_IRQ_MASK:
                  irq_mask <= wdata_i[2:0];
               default:
                  ;
            endcase
         end
         // dynamic write in run mode arms a pending update
         if (wr_i && run_s2 && (addr_i == `REG_DYN_CH || addr_i == `REG_DYN_CYC))
            dyn_pend <= 1'b1;
         if (go_run)
         begin
            act_diag_irq_en <= ld_diag_irq_en;
            act_diag_en     <= ld_diag_en;
            act_wb_en       <= ld_wb_en;
            act_dyn         <= ld_dyn;
            act_cyc_en      <= ld_cyc_en;
            act_ival        <= ld_ival;
            dyn_pend        <= 1'b0;
         end
         else if (dyn_pend && boundary && !wr_i)
         begin
            act_dyn    <= ld_dyn;
            act_cyc_en <= ld_cyc_en;
            act_ival   <= ld_ival;
            dyn_pend   <= 1'b0;
         end
      end
   end
   assign diag_irq_en_o = act_diag_irq_en;

   // =====================================================
   // channel search and interval tick
   chan_select u_sel (
      .active_i (active),
      .from_i   (next_ch),
      .found_o  (sel_found),
      .chan_o   (sel_ch)
   );

   half_ms_tick #(
      .CYCLES (HALF_MS)
   ) u_tick (
      .clk_i     (clk_i),
      .nrst_i    (nrst_i),
      .restart_i (go_run),
      .tick_o    (tick)
   );

   // =====================================================
   // measurement sequencer and interval timer
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state        <= S_IDLE;
         next_ch      <= 3'd0;
         ival_cnt     <= 6'h00;
         hw_irq       <= 1'b0;
         conv_start_o <= 1'b0;
         conv_chan_o  <= 2'b00;
         conv_range_o <= 2'b00;
         wbreak       <= 4'h0;
      end
      else
      begin
         conv_start_o <= 1'b0;
         hw_irq       <= 1'b0;
         // interval count in half-ms, irq and restart at expiry
         if (!run_s2 || !act_cyc_en || act_ival == 6'h00)
            ival_cnt <= 6'h00;
         else if (tick)
         begin
            if (ival_cnt + 6'h01 >= act_ival)
            begin
               ival_cnt <= 6'h00;
               hw_irq   <= 1'b1;
            end
            else
               ival_cnt <= ival_cnt + 6'h01;
         end
         case (state)
            S_IDLE:
               if (run_s2 && act_cyc_en && (applied || hw_irq || act_ival == 6'h00))
               begin
                  next_ch <= 3'd0;
                  state   <= S_PICK;
               end
            S_PICK:
               if (sel_found)
               begin
                  conv_chan_o  <= sel_ch;
                  conv_range_o <= sel_fld[3:2];
                  conv_start_o <= 1'b1;
                  state        <= S_CONV;
               end
               else
                  state <= S_IDLE;
            S_CONV:
               state <= S_WAIT;
            S_WAIT:
               if (conv_done_i)
               begin
                  // wire break only on 4-20 mA with check enabled
                  wbreak[conv_chan_o] <= conv_open_i && act_wb_en[conv_chan_o] &&
                     (conv_range_o == `MRANGE_4_20MA);
                  next_ch <= {1'b0, conv_chan_o} + 3'd1;
                  state   <= S_PICK;
               end
            default:
               state <= S_IDLE;
         endcase
      end
   end

   // hold each result for the cpu
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         result[0] <= 16'h0000;
         result[1] <= 16'h0000;
         result[2] <= 16'h0000;
         result[3] <= 16'h0000;
      end
      else if (state == S_WAIT && conv_done_i)
         result[conv_chan_o] <= conv_data_i;
   end

   // =====================================================
   // sticky interrupt status, set wins over clear
   assign cyc_event  = hw_irq;
   assign wb_event   = state == S_WAIT && conv_done_i && conv_open_i &&
                       act_wb_en[conv_chan_o] && act_diag_en[conv_chan_o] &&
                       (conv_range_o == `MRANGE_4_20MA);
   assign done_event = state == S_PICK && !sel_found;
   assign irq_set    = {done_event, wb_event, cyc_event};

   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         irq_stat <= 3'h0;
      else
         irq_stat <= (irq_stat & ~((wr_i && addr_i == `REG_IRQ_STAT) ?
                      wdata_i[2:0] : 3'h0)) | irq_set;
   end
   assign irq_o    = |(irq_stat & irq_mask);
   assign hw_irq_o = hw_irq;

   // =====================================================
   // read data, one cycle after the strobe
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rdata_o <= 32'h0000_0000;
      else if (rd_i)
      begin
         case (addr_i)
            `REG_CTRL:     rdata_o <= {29'h0, dyn_pend, run_s2, act_cyc_en};
            `REG_STATIC:   rdata_o <= {20'h0, ld_wb_en, ld_diag_en, 3'h0, ld_diag_irq_en};
            `REG_DYN_CH:   rdata_o <= {16'h0, ld_dyn};
            `REG_DYN_CYC:  rdata_o <= {23'h0, ld_cyc_en, 2'h0, ld_ival};
            `REG_STATUS:   rdata_o <= {20'h0, wbreak, 4'h0, active};
            `REG_IRQ_STAT: rdata_o <= {29'h0, irq_stat};
            `REG_IRQ_MASK: rdata_o <= {29'h0, irq_mask};
            8'h20:         rdata_o <= {16'h0, result[0]};
            8'h24:         rdata_o <= {16'h0, result[1]};
            8'h28:         rdata_o <= {16'h0, result[2]};
            8'h2C:         rdata_o <= {16'h0, result[3]};
            default:       rdata_o <= 32'h0000_0000;
         endcase
      end
      else
         rdata_o <= 32'h0000_0000;
   end
endmodule // analog_input_param_cycle_ctrl

// ===== verilog/chan_select.v
`timescale 1ns/1ps
// =====================================================
// next active channel at or after a given one (skip deactivated)
module chan_select (
   // inputs
   input  wire [3:0] active_i,
   input  wire [2:0] from_i,
   // outputs
   output reg        found_o,
   output reg  [1:0] chan_o
);
   integer k;

   // lowest active channel with index >= from_i
   always @*
   begin
      found_o = 1'b0;
      chan_o  = 2'b00;
      for (k = 3; k >= 0; k = k - 1)
         if (active_i[k] && (k >= from_i))
         begin
            found_o = 1'b1;
            chan_o  = k[1:0];
         end
   end
endmodule // chan_select

// ===== verilog/half_ms_tick.v
`timescale 1ns/1ps
// =====================================================
// half-millisecond tick generator
module half_ms_tick #(
   parameter integer CYCLES = 25000
) (
   // clock and reset
   input  wire clk_i,
   input  wire nrst_i,
   // control
   input  wire restart_i,
   output reg  tick_o
);
   reg [15:0] cnt;

   // count down, pulse at zero
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cnt    <= 16'h0000;
         tick_o <= 1'b0;
      end
      else if (restart_i || cnt == 16'h0000)
      begin
         cnt    <= CYCLES[15:0] - 16'h0001;
         tick_o <= !restart_i && (cnt == 16'h0000);
      end
      else
      begin
         cnt    <= cnt - 16'h0001;
         tick_o <= 1'b0;
      end
   end
endmodule // half_ms_tick
